// ===== design/coproc_sqr_defs.vh
// Constants for the square and square-root instruction decoder.
// Assumes a 32-bit coprocessor instruction word and 64-bit registers.
`ifndef COPROC_SQR_DEFS_VH
`define COPROC_SQR_DEFS_VH

// ****************************************
// Instruction word fields
// ****************************************
`define SEL_HI 31
`define SEL_LO 29
`define SRC_HI 28
`define SRC_LO 25
`define OP_HI 24
`define OP_LO 21
`define DST_HI 20
`define DST_LO 16
`define CLS_HI 15
`define CLS_LO 12
`define FIX_HI 11
`define FIX_LO 9
`define TYPE_BIT 8
`define SIZE_BIT 7

// ****************************************
// Field codes
// ****************************************
`define FIX_ONES 3'h7
`define OP_SQUARE 4'h8
`define OP_ROOT 4'h9
`define OP_ABS_ROOT 4'hA
`define CLS_INTERNAL 4'h1
`define CLS_HOST 4'h5
`define CLS_MEMORY 4'h9

// ****************************************
// Number formats and timing
// ****************************************
`define DBL_BIAS 13'h03FF
`define SGL_BIAS 13'h007F
`define DBL_EXP_MAX 13'h07FE
`define SGL_EXP_MAX 13'h00FE
`define ADDR_STEP_BITS 8'h20
`define ROOT_STEPS 7'h36
`define RF_RESET 64'h0000000000000000

`endif

// ===== design/root_iter.v
// Iterative restoring square root, one result bit per clock.
// Assumes start_in is only pulsed while done is not pending.
`default_nettype none
`include "coproc_sqr_defs.vh"

module root_iter #(
    parameter RW = 54
) (
    // Clock and reset
    input wire core_clk_in,
    input wire nrst_in,
    // Request
    input wire start_in,
    input wire [2*RW-1:0] rad_in,
    // Answer
    output reg done_out,
    output reg [RW-1:0] root_out
);

// ****************************************
// Working registers
// ****************************************
reg [2*RW-1:0] rad_reg;
reg [RW+1:0] rem_reg;
reg [6:0] cnt_reg;
wire [RW+1:0] rem_try;
wire [RW+1:0] trial;
wire fits;

// Next partial remainder against the trial subtrahend
assign rem_try = {rem_reg[RW-1:0], rad_reg[2*RW-1:2*RW-2]};
assign trial = {root_out, 2'b01};
assign fits = (rem_try >= trial);

// One bit of root per step, pulse done after the last
always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        rad_reg <= {2*RW{1'b0}};
        rem_reg <= {(RW+2){1'b0}};
        root_out <= {RW{1'b0}};
        cnt_reg <= 7'h00;
        done_out <= 1'b0;
    end else begin
        done_out <= 1'b0;
        if (start_in) begin
            rad_reg <= rad_in;
            rem_reg <= {(RW+2){1'b0}};
            root_out <= {RW{1'b0}};
            cnt_reg <= `ROOT_STEPS;
        end else if (cnt_reg != 7'h00) begin
            rad_reg <= {rad_reg[2*RW-3:0], 2'b00};
            rem_reg <= fits ? rem_try - trial : rem_try;
            root_out <= {root_out[RW-2:0], fits};
            cnt_reg <= cnt_reg - 7'h01;
            done_out <= (cnt_reg == 7'h01);
        end
    end
end

endmodule // root_iter

`default_nettype wire

// ===== design/coproc_square_root_decode.v
// Square / square-root instruction decoder and executor for the coprocessor.
// Assumes the host presents instruction words and operand words on
// synchronous valid/ready handshakes and moves its own address register.
//
// What this block does
// - Square multiplies the source register by itself into the destination.
// - Pre-decrement memory form steps the host address down 32 before each load word.
// - Post-increment memory form loads the word then steps the host address up 32.
// - Square root writes the root of the source register to the destination.
// - Absolute square root drops the operand sign before taking the root.
// - Host-register form stores the host value in the source before the root.
// - Double host-register form joins two host words into one source register.
// - Memory forms store the fetched word in the source before the root.
// - Select is bits 31-29, source 28-25, operation 24-21, destination 20-16.
// - Single-precision selection reads the operand in single format.
`default_nettype none
`include "coproc_sqr_defs.vh"

module coproc_square_root_decode #(
    parameter [2:0] COPROC_SELECT = 3'h0
) (
    // Clock and reset
    input wire core_clk_in,
    input wire nrst_in,
    // Instruction handshake
    input wire instr_valid_in,
    input wire [31:0] instr_in,
    input wire instr_predec_in,
    output reg instr_ready_out,
    // Operand word handshake and address stepping
    input wire word_valid_in,
    input wire [31:0] word_in,
    output reg word_ready_out,
    output reg addr_step_out,
    output reg addr_step_down_out,
    // Completion
    output reg done_out,
    output reg invalid_out,
    output reg reject_out,
    output reg [63:0] result_out,
    // Register peek
    input wire [4:0] peek_index_in,
    output reg [63:0] peek_data_out
);

// ****************************************
// States and storage
// ****************************************
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_STEP = 3'h1;
localparam [2:0] ST_WORD = 3'h2;
localparam [2:0] ST_EXEC = 3'h3;
localparam [2:0] ST_ROOT = 3'h4;

reg [2:0] state_reg;
reg [3:0] op_reg;
reg [3:0] cls_reg;
reg flt_reg;
reg dbl_reg;
reg predec_reg;
reg [3:0] src_reg;
reg [4:0] dst_reg;
reg second_reg;
reg [63:0] rf [0:31];
reg [12:0] exp_reg;
reg zero_reg;
reg root_start_reg;
reg [107:0] rad_reg;
integer i;

wire root_done;
wire [53:0] root_val;
wire sel_hit;
wire op_ok;
wire cls_ok;
wire word_take;
wire [63:0] src_val;

// Source always comes from the first bank
assign src_val = rf[{1'b0, src_reg}];
assign sel_hit = (instr_in[`SEL_HI:`SEL_LO] == COPROC_SELECT);
assign op_ok = (instr_in[`OP_HI:`OP_LO] == `OP_SQUARE)
    || (instr_in[`OP_HI:`OP_LO] == `OP_ROOT)
    || (instr_in[`OP_HI:`OP_LO] == `OP_ABS_ROOT);
assign cls_ok = ((instr_in[`CLS_HI:`CLS_LO] == `CLS_INTERNAL)
    || (instr_in[`CLS_HI:`CLS_LO] == `CLS_HOST)
    || (instr_in[`CLS_HI:`CLS_LO] == `CLS_MEMORY))
    && (instr_in[`FIX_HI:`FIX_LO] == `FIX_ONES);
assign word_take = (state_reg == ST_WORD) && word_valid_in && word_ready_out;

// ****************************************
// Floating-point packing
// ****************************************
function [63:0] pack_fp;
    input dbl;
    input [12:0] e;
    input [52:0] m;
    reg [12:0] eb;
    begin
        eb = e + (dbl ? `DBL_BIAS : `SGL_BIAS);
        if ($signed(eb) < $signed(13'h0001)) begin
            pack_fp = 64'h0000000000000000;
        end else if (dbl) begin
            if ($signed(eb) > $signed(`DBL_EXP_MAX)) begin
                pack_fp = 64'h7FF0000000000000;
            end else begin
                pack_fp = {1'b0, eb[10:0], m[51:0]};
            end
        end else if ($signed(eb) > $signed(`SGL_EXP_MAX)) begin
            pack_fp = 64'h000000007F800000;
        end else begin
            pack_fp = {32'h00000000, 1'b0, eb[7:0], m[51:29]};
        end
    end
endfunction

// ****************************************
// Operand unpacking and square datapath
// ****************************************
reg u_sign;
reg u_zero;
reg [12:0] u_exp;
reg [52:0] u_mant;
reg [31:0] i_mag;
reg [63:0] i_prod;
reg [105:0] f_prod;
reg [63:0] sq_res;
reg [107:0] rad_next;

// Split the source by type and size, then form square and radicand
always @* begin
    u_sign = 1'b0;
    u_zero = 1'b0;
    u_exp = 13'h0000;
    u_mant = 53'h0;
    if (dbl_reg) begin
        u_sign = src_val[63];
        u_zero = (src_val[62:52] == 11'h000);
        u_exp = {2'b00, src_val[62:52]} - `DBL_BIAS;
        u_mant = {1'b1, src_val[51:0]};
    end else begin
        u_sign = src_val[31];
        u_zero = (src_val[30:23] == 8'h00);
        u_exp = {5'h00, src_val[30:23]} - `SGL_BIAS;
        u_mant = {1'b1, src_val[22:0], 29'h0};
    end
    i_mag = src_val[31] ? (32'h0 - src_val[31:0]) : src_val[31:0];
    i_prod = src_val[31:0] * src_val[31:0];
    f_prod = u_mant * u_mant;
    if (!flt_reg) begin
        sq_res = {32'h00000000, i_prod[31:0]};
    end else if (u_zero) begin
        sq_res = 64'h0000000000000000;
    end else if (f_prod[105]) begin
        sq_res = pack_fp(dbl_reg, {u_exp[11:0], 1'b1}, f_prod[105:53]);
    end else begin
        sq_res = pack_fp(dbl_reg, {u_exp[11:0], 1'b0}, f_prod[104:52]);
    end
    // Odd exponents feed a doubled mantissa so the root stays normalised
    if (!flt_reg) begin
        rad_next = {76'h0, i_mag};
    end else if (u_exp[0]) begin
        rad_next = {2'b00, u_mant, 53'h0};
    end else begin
        rad_next = {3'b000, u_mant, 52'h0};
    end
end

// ****************************************
// Sequencer and register file
// ****************************************
always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        state_reg <= ST_IDLE;
        op_reg <= 4'h0;
        cls_reg <= 4'h0;
        flt_reg <= 1'b0;
        dbl_reg <= 1'b0;
        predec_reg <= 1'b0;
        src_reg <= 4'h0;
        dst_reg <= 5'h00;
        second_reg <= 1'b0;
        exp_reg <= 13'h0000;
        zero_reg <= 1'b0;
        root_start_reg <= 1'b0;
        rad_reg <= 108'h0;
        instr_ready_out <= 1'b0;
        word_ready_out <= 1'b0;
        addr_step_out <= 1'b0;
        addr_step_down_out <= 1'b0;
        done_out <= 1'b0;
        invalid_out <= 1'b0;
        reject_out <= 1'b0;
        result_out <= 64'h0000000000000000;
        for (i = 0; i < 32; i = i + 1) begin
            rf[i] <= `RF_RESET;
        end
    end else begin
        done_out <= 1'b0;
        invalid_out <= 1'b0;
        reject_out <= 1'b0;
        addr_step_out <= 1'b0;
        root_start_reg <= 1'b0;
        instr_ready_out <= 1'b0;
        case (state_reg)
            ST_IDLE: begin
                instr_ready_out <= 1'b1;
                if (instr_valid_in && instr_ready_out) begin
                    instr_ready_out <= 1'b0;
                    op_reg <= instr_in[`OP_HI:`OP_LO];
                    cls_reg <= instr_in[`CLS_HI:`CLS_LO];
                    src_reg <= instr_in[`SRC_HI:`SRC_LO];
                    dst_reg <= instr_in[`DST_HI:`DST_LO];
                    flt_reg <= instr_in[`TYPE_BIT];
                    dbl_reg <= instr_in[`TYPE_BIT] & instr_in[`SIZE_BIT];
                    predec_reg <= instr_predec_in;
                    second_reg <= 1'b0;
                    if (!(sel_hit && op_ok && cls_ok)) begin
                        reject_out <= sel_hit;
                        instr_ready_out <= 1'b1;
                    end else if (instr_in[`CLS_HI:`CLS_LO] == `CLS_INTERNAL) begin
                        state_reg <= ST_EXEC;
                    end else if ((instr_in[`CLS_HI:`CLS_LO] == `CLS_MEMORY)
                        && instr_predec_in) begin
                        state_reg <= ST_STEP;
                    end else begin
                        state_reg <= ST_WORD;
                        word_ready_out <= 1'b1;
                    end
                end
            end
            ST_STEP: begin
                // Address moves down before the word is fetched
                addr_step_out <= 1'b1;
                addr_step_down_out <= 1'b1;
                word_ready_out <= 1'b1;
                state_reg <= ST_WORD;
            end
            ST_WORD: begin
                if (word_take) begin
                    word_ready_out <= 1'b0;
                    if (dbl_reg && !second_reg) begin
                        rf[{1'b0, src_reg}][63:32] <= word_in;
                    end else if (dbl_reg) begin
                        rf[{1'b0, src_reg}][31:0] <= word_in;
                    end else begin
                        rf[{1'b0, src_reg}] <= {32'h00000000, word_in};
                    end
                    // Post-increment steps after the word is taken
                    if ((cls_reg == `CLS_MEMORY) && !predec_reg) begin
                        addr_step_out <= 1'b1;
                        addr_step_down_out <= 1'b0;
                    end
                    second_reg <= 1'b1;
                    if (dbl_reg && !second_reg) begin
                        if ((cls_reg == `CLS_MEMORY) && predec_reg) begin
                            state_reg <= ST_STEP;
                        end else begin
                            word_ready_out <= 1'b1;
                        end
                    end else begin
                        state_reg <= ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                if (op_reg == `OP_SQUARE) begin
                    rf[dst_reg] <= sq_res;
                    result_out <= sq_res;
                    done_out <= 1'b1;
                    state_reg <= ST_IDLE;
                end else begin
                    // Plain root of a negative value is flagged and gives zero
                    invalid_out <= (op_reg == `OP_ROOT) && (flt_reg
                        ? (u_sign && !u_zero) : src_val[31]);
                    zero_reg <= (flt_reg && u_zero)
                        || ((op_reg == `OP_ROOT) && (flt_reg
                        ? u_sign : src_val[31]));
                    exp_reg <= {u_exp[12], u_exp[12:1]};
                    rad_reg <= rad_next;
                    root_start_reg <= 1'b1;
                    state_reg <= ST_ROOT;
                end
            end
            ST_ROOT: begin
                if (root_done) begin
                    if (zero_reg) begin
                        rf[dst_reg] <= 64'h0000000000000000;
                        result_out <= 64'h0000000000000000;
                    end else if (!flt_reg) begin
                        rf[dst_reg] <= {32'h00000000, root_val[31:0]};
                        result_out <= {32'h00000000, root_val[31:0]};
                    end else begin
                        rf[dst_reg] <= pack_fp(dbl_reg, exp_reg,
                            root_val[52:0]);
                        result_out <= pack_fp(dbl_reg, exp_reg,
                            root_val[52:0]);
                    end
                    done_out <= 1'b1;
                    state_reg <= ST_IDLE;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

// Registered view of any coprocessor register
always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        peek_data_out <= 64'h0000000000000000;
    end else begin
        peek_data_out <= rf[peek_index_in];
    end
end

// ****************************************
// Root engine
// ****************************************
root_iter #(
    .RW(54)
) root_iter_inst (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .start_in(root_start_reg),
    .rad_in(rad_reg),
    .done_out(root_done),
    .root_out(root_val)
);

endmodule // coproc_square_root_decode

`default_nettype wire

// ===== bench/coproc_sqr_props.sv
// Port checker for the square and square-root decoder.
// Assumes it is bound to the decoder and sees only its ports.
`default_nettype none
// ****************************************
// Checker
// ****************************************
module coproc_sqr_props #(
    parameter logic [2:0] COPROC_SELECT = 3'h0
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic instr_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic instr_predec_in,
    input wire logic instr_ready_out,
    input wire logic word_valid_in,
    input wire logic word_ready_out,
    input wire logic addr_step_out,
    input wire logic addr_step_down_out,
    input wire logic done_out,
    input wire logic invalid_out,
    input wire logic reject_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take, word_take, sel_ok, good, mem_ok, pre_reg, post_reg;
    logic [3:0] op, cls;
    // Field decode of the word offered for taking
    assign take = instr_valid_in && instr_ready_out;
    assign word_take = word_valid_in && word_ready_out;
    assign op = instr_in[24:21];
    assign cls = instr_in[15:12];
    assign sel_ok = instr_in[31:29] == COPROC_SELECT;
    assign good = op inside {4'h8, 4'h9, 4'hA} && instr_in[11:9] == 3'h7 &&
        cls inside {4'h1, 4'h5, 4'h9};
    assign mem_ok = sel_ok && good && cls == 4'h9;
    // Memory form of the last taken instruction
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_reg <= 1'b0;
            post_reg <= 1'b0;
        end else if (take) begin
            pre_reg <= mem_ok && instr_predec_in;
            post_reg <= mem_ok && !instr_predec_in;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_exec;
        !instr_ready_out ##1 done_out;
    endsequence
    sequence s_root;
        ##[20:70] done_out;
    endsequence
    property p_square_done;
        take && sel_ok && good && op == 4'h8 && cls == 4'h1 |=> s_exec;
    endproperty
    a_square_done: assert property (p_square_done)
        else $error("square not written two cycles after take");
    property p_root_done;
        take && sel_ok && good && op == 4'hA && cls == 4'h1 |-> s_root;
    endproperty
    a_root_done: assert property (p_root_done)
        else $error("root result late");
    property p_other_sel;
        take && !sel_ok |=> (!done_out && !reject_out && !invalid_out)[*4];
    endproperty
    a_other_sel: assert property (p_other_sel)
        else $error("word for another unit answered");
    property p_reject;
        take && sel_ok && !good |=> !done_out throughout (##[0:2] reject_out);
    endproperty
    a_reject: assert property (p_reject)
        else $error("bad word not refused");
    property p_predec_step;
        pre_reg && $rose(word_ready_out) |-> addr_step_out && addr_step_down_out;
    endproperty
    a_predec_step: assert property (p_predec_step)
        else $error("no down step before load");
    property p_postinc_step;
        post_reg && word_take |=> addr_step_out && !addr_step_down_out;
    endproperty
    a_postinc_step: assert property (p_postinc_step)
        else $error("no up step after load");
    property p_step_mem;
        addr_step_out |-> pre_reg || post_reg;
    endproperty
    a_step_mem: assert property (p_step_mem)
        else $error("address step outside memory form");
    property p_mem_word;
        (pre_reg || post_reg) && word_take |-> ##[1:70] (done_out || addr_step_out);
    endproperty
    a_mem_word: assert property (p_mem_word)
        else $error("loaded word not followed by result");
endmodule // coproc_sqr_props

bind coproc_square_root_decode coproc_sqr_props #(
    .COPROC_SELECT(COPROC_SELECT)
) coproc_sqr_props_inst (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .instr_predec_in(instr_predec_in), .instr_ready_out(instr_ready_out),
    .word_valid_in(word_valid_in), .word_ready_out(word_ready_out),
    .addr_step_out(addr_step_out), .addr_step_down_out(addr_step_down_out),
    .done_out(done_out), .invalid_out(invalid_out), .reject_out(reject_out)
);
`default_nettype wire

// ===== bench/host_issuer_model.sv
// Behavioural host that hands operand words and moves its address register.
// Assumes the bench loads one or two words before each load instruction.
`default_nettype none
// ****************************************
// Host model
// ****************************************
module host_issuer_model (
    // Clock, reset and bench control
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic load_in,
    input wire logic two_in,
    input wire logic slow_in,
    input wire logic [31:0] hi_in,
    input wire logic [31:0] lo_in,
    // Device side
    input wire logic word_ready_in,
    input wire logic step_in,
    input wire logic step_down_in,
    output logic word_valid_out,
    output logic [31:0] word_out,
    output logic [31:0] addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pend_reg, dly_reg;
    logic idx_reg;
    logic [31:0] last_reg;
    // Offer words, slowly when asked; a released line shows the inverse
    assign word_valid_out = pend_reg != 2'h0 && (!slow_in || dly_reg == 2'h3);
    assign word_out = !word_valid_out ? ~last_reg : idx_reg ? lo_in : hi_in;
    // Word hand-over and address stepping
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pend_reg <= 2'h0;
            dly_reg <= 2'h0;
            idx_reg <= 1'b0;
            last_reg <= 32'h0;
            addr_out <= 32'h00001000;
        end else begin
            if (load_in) begin
                pend_reg <= two_in ? 2'h2 : 2'h1;
                idx_reg <= 1'b0;
            end else if (word_valid_out && word_ready_in) begin
                pend_reg <= pend_reg - 2'h1;
                idx_reg <= 1'b1;
                dly_reg <= 2'h0;
                last_reg <= word_out;
            end else if (pend_reg != 2'h0 && word_ready_in && dly_reg != 2'h3) begin
                dly_reg <= dly_reg + 2'h1;
            end
            if (step_in) begin
                addr_out <= step_down_in ? addr_out - 32'h20 : addr_out + 32'h20;
            end
        end
    end
endmodule // host_issuer_model
`default_nettype wire

// ===== bench/test_coproc_square_root_decode.sv
// Self-checking bench for the square and square-root decoder.
// Assumes the host model in its own file and the bound port checker.
`default_nettype none
// ****************************************
// Bench
// ****************************************
module test_coproc_square_root_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in, nrst_in, instr_valid_in, instr_predec_in;
    logic load, two, slow, instr_ready_out, word_valid_in, word_ready_out;
    logic addr_step_out, addr_step_down_out, done_out, invalid_out, reject_out;
    logic [4:0] peek_index_in;
    logic [31:0] instr_in, word_in, hi, lo, host_addr, base;
    logic [63:0] result_out, peek_data_out, res;
    logic [2:0] flags;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    coproc_square_root_decode coproc_square_root_decode_inst (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in),
        .instr_predec_in(instr_predec_in), .instr_ready_out(instr_ready_out),
        .word_valid_in(word_valid_in), .word_in(word_in),
        .word_ready_out(word_ready_out), .addr_step_out(addr_step_out),
        .addr_step_down_out(addr_step_down_out), .done_out(done_out),
        .invalid_out(invalid_out), .reject_out(reject_out),
        .result_out(result_out), .peek_index_in(peek_index_in),
        .peek_data_out(peek_data_out));
    host_issuer_model host_issuer_model_inst (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .load_in(load),
        .two_in(two), .slow_in(slow), .hi_in(hi), .lo_in(lo),
        .word_ready_in(word_ready_out), .step_in(addr_step_out),
        .step_down_in(addr_step_down_out), .word_valid_out(word_valid_in),
        .word_out(word_in), .addr_out(host_addr));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Sources always come from the first bank
    function automatic logic [31:0] mk(input logic [3:0] op, src,
        input logic [4:0] dst, input logic [3:0] cls, input logic t, s);
        mk = {3'h0, src, op, dst, cls, 3'h7, t, s, 7'h00};
    endfunction
    // Issue one instruction and collect pulses until idle again
    task automatic run(input logic [31:0] w, input logic pre);
        int n;
        n = 0;
        while (instr_ready_out !== 1'b1 && n < 200) begin
            @(negedge core_clk_in);
            n++;
        end
        instr_in = w;
        instr_predec_in = pre;
        instr_valid_in = 1'b1;
        @(negedge core_clk_in);
        instr_valid_in = 1'b0;
        // A refusal pulses while ready is still high, so look before leaving
        flags = {done_out, invalid_out, reject_out};
        n = 0;
        while (instr_ready_out !== 1'b1 && n < 200) begin
            flags = flags | {done_out, invalid_out, reject_out};
            if (done_out === 1'b1) res = result_out;
            @(negedge core_clk_in);
            n++;
        end
        if (n >= 200) chk(64'h1, 64'h0);
    endtask
    // Load the host model with operand words
    task automatic give(input logic t, input logic [31:0] h, l, input logic s);
        two = t;
        hi = h;
        lo = l;
        slow = s;
        load = 1'b1;
        @(negedge core_clk_in);
        load = 1'b0;
        base = host_addr;
    endtask
    task automatic peek(input logic [4:0] i, input logic [63:0] exp);
        peek_index_in = i;
        @(negedge core_clk_in);
        chk(peek_data_out, exp);
    endtask
    task automatic t_square;
        give(1'b0, 32'h7, 32'h0, 1'b0);
        run(mk(4'h8, 4'h1, 5'h05, 4'h5, 1'b0, 1'b0), 1'b0);
        chk(res, 64'h31);
        chk(flags, 3'h4);
        peek(5'h01, 64'h7);
        run(mk(4'h8, 4'h5, 5'h06, 4'h1, 1'b0, 1'b0), 1'b0);
        chk(res, 64'h961);
        give(1'b0, 32'h40400000, 32'h0, 1'b0);
        run(mk(4'h8, 4'h2, 5'h09, 4'h5, 1'b1, 1'b0), 1'b0);
        chk(res, 64'h41100000);
    endtask
    task automatic t_internal_root;
        run(mk(4'h9, 4'h6, 5'h07, 4'h1, 1'b0, 1'b0), 1'b0);
        chk(res, 64'h31);
        run(mk(4'hA, 4'h5, 5'h08, 4'h1, 1'b0, 1'b0), 1'b0);
        chk(res, 64'h7);
    endtask
    task automatic t_predec;
        give(1'b0, 32'h40800000, 32'h0, 1'b1);
        run(mk(4'h9, 4'h3, 5'h0A, 4'h9, 1'b1, 1'b0), 1'b1);
        chk(res, 64'h40000000);
        chk(host_addr, base - 32'h20);
        give(1'b1, 32'h40080000, 32'h0, 1'b0);
        run(mk(4'h8, 4'h3, 5'h0C, 4'h9, 1'b1, 1'b1), 1'b1);
        chk(res, 64'h4022000000000000);
        chk(host_addr, base - 32'h40);
    endtask
    task automatic t_postinc;
        give(1'b1, 32'hC0100000, 32'h0, 1'b0);
        run(mk(4'hA, 4'h4, 5'h0B, 4'h9, 1'b1, 1'b1), 1'b0);
        chk(res, 64'h4000000000000000);
        chk(host_addr, base + 32'h40);
        peek(5'h04, 64'hC010000000000000);
    endtask
    task automatic t_host_root;
        give(1'b1, 32'h40220000, 32'h0, 1'b1);
        run(mk(4'h9, 4'h6, 5'h0D, 4'h5, 1'b1, 1'b1), 1'b0);
        chk(res, 64'h4008000000000000);
        peek(5'h06, 64'h4022000000000000);
        give(1'b0, 32'hFFFFFF9C, 32'h0, 1'b0);
        run(mk(4'h9, 4'h7, 5'h0E, 4'h5, 1'b0, 1'b0), 1'b0);
        chk(flags[1], 1'b1);
        give(1'b0, 32'hFFFFFF9C, 32'h0, 1'b0);
        run(mk(4'hA, 4'h7, 5'h0F, 4'h5, 1'b0, 1'b0), 1'b0);
        chk(res, 64'hA);
        peek(5'h07, 64'hFFFFFF9C);
    endtask
    task automatic t_refuse;
        run(mk(4'h8, 4'h1, 5'h10, 4'h1, 1'b0, 1'b0) & 32'hFFFFFDFF, 1'b0);
        chk(flags, 3'h1);
        run(mk(4'h3, 4'h1, 5'h10, 4'h1, 1'b0, 1'b0), 1'b0);
        chk(flags, 3'h1);
        run(mk(4'h8, 4'h1, 5'h10, 4'h2, 1'b0, 1'b0), 1'b0);
        chk(flags, 3'h1);
        run(mk(4'h8, 4'h1, 5'h10, 4'h1, 1'b0, 1'b0) | 32'h20000000, 1'b0);
        chk(flags, 3'h0);
        peek(5'h10, 64'h0);
    endtask
    task automatic end_sim;
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Clock and hang guard
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    initial begin
        forever begin
            @(posedge core_clk_in);
            cycles++;
            if (cycles > 5000) begin
                err_count++;
                end_sim;
            end
        end
    end
    // Main sequence
    initial begin
        {nrst_in, instr_valid_in, instr_predec_in, load, two, slow} = 6'h0;
        {instr_in, hi, lo} = 96'h0;
        peek_index_in = 5'h00;
        repeat (4) @(negedge core_clk_in);
        nrst_in = 1'b1;
        @(negedge core_clk_in);
        t_square;
        t_internal_root;
        t_predec;
        t_postinc;
        t_host_root;
        t_refuse;
        end_sim;
    end
endmodule // test_coproc_square_root_decode
`default_nettype wire
